/* hdl/acr_cal_regs.v */
// calibration registers, result correction and serial register access
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_cal_regs (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        master_mode_i,
    input  wire        output_format_select_i,
    input  wire [23:0] raw_result_i,
    input  wire        raw_valid_i,
    input  wire        result_ack_i,
    input  wire        cal_offset_load_i,
    input  wire        cal_fullscale_load_i,
    input  wire [23:0] cal_word_i,
    input  wire        cs_n_i,
    input  wire        sclk_i,
    input  wire        sdio_i,
    output reg         sclk_o,
    output reg         sclk_oe_n_o,
    output reg         serial_data_out_o,
    output reg  [23:0] output_result_register_o,
    output reg         result_ready_n_o,
    output reg  [23:0] offset_correction_o,
    output reg  [23:0] fullscale_correction_o
);

// ---------------------------------------------------------------
// helpers
// ---------------------------------------------------------------
    // clamp the wide product back into a 24-bit signed result
    function [23:0] saturate;
        input [48:0] value;
        begin
            if (!value[48] && (|value[47:23])) begin
                saturate = `ACR_RESULT_MAX;
            end else if (value[48] && !(&value[47:23])) begin
                saturate = `ACR_RESULT_MIN;
            end else begin
                saturate = value[23:0];
            end
        end
    endfunction

// ---------------------------------------------------------------
// pin synchronisers
// ---------------------------------------------------------------
    reg [1:0] cs_sync;
    reg [1:0] sclk_sync;
    reg [1:0] sdio_sync;
    reg [1:0] mode_sync;
    // third stage of the clock pin, kept only to find its edges
    // the mode pin is taken as static while a frame is open
    reg       sclk_seen;

    always @(posedge clock_i) begin
        if (rst_i) begin
            cs_sync   <= 2'h3;
            sclk_sync <= 2'h0;
            sdio_sync <= 2'h0;
            mode_sync <= 2'h0;
            sclk_seen <= 1'b0;
        end else begin
            cs_sync   <= {cs_sync[0], cs_n_i};
            sclk_sync <= {sclk_sync[0], sclk_i};
            sdio_sync <= {sdio_sync[0], sdio_i};
            mode_sync <= {mode_sync[0], master_mode_i};
            sclk_seen <= sclk_sync[1];
        end
    end

    wire cs_active = ~cs_sync[1];
    wire is_master = mode_sync[1];

// ---------------------------------------------------------------
// serial clock: generated in master mode, sampled in slave mode
// ---------------------------------------------------------------
    reg  [5:0] bit_cnt;
    reg  [1:0] phase_cnt;
    wire       gen_run = is_master && cs_active && (bit_cnt != `ACR_FRAME_BITS);
    wire [1:0] phase_end = sclk_o ? `ACR_SCLK_HIGH_CYCLES : `ACR_SCLK_LOW_CYCLES;
    wire       gen_toggle = gen_run && (phase_cnt == phase_end);
    // slave edges lag the pin by the synchroniser; the host's eight-period phases
    // leave ample room for that delay
    wire       rise_ev = is_master ? (gen_toggle && !sclk_o)
                                   : (sclk_sync[1] && !sclk_seen);
    wire       fall_ev = is_master ? (gen_toggle && sclk_o)
                                   : (!sclk_sync[1] && sclk_seen);

    always @(posedge clock_i) begin
        if (rst_i) begin
            sclk_o      <= 1'b0;
            sclk_oe_n_o <= 1'b1;
            phase_cnt   <= 2'h0;
        end else begin
            // the pin clock is never driven in slave mode, so host and device cannot fight
            sclk_oe_n_o <= ~is_master;
            if (!gen_run) begin
                sclk_o    <= 1'b0;
                phase_cnt <= 2'h0;
            end else if (gen_toggle) begin
                sclk_o    <= ~sclk_o;
                phase_cnt <= 2'h0;
            end else begin
                phase_cnt <= phase_cnt + 2'h1;
            end
        end
    end

// ---------------------------------------------------------------
// frame engine: command byte then 24 data bits, msb first
// ---------------------------------------------------------------
    reg  [7:0]  cmd;
    reg  [23:0] in_shift;
    reg  [23:0] out_shift;
    wire [5:0]  next_bit_cnt = bit_cnt + 6'h01;
    wire        cmd_read = cmd[`ACR_CMD_READ_BIT];
    wire        cmd_sel  = cmd[`ACR_CMD_SEL_BIT];
    wire        in_data  = (bit_cnt >= `ACR_CMD_BITS);
    wire        write_done = fall_ev && cs_active && in_data && !cmd_read
                             && (next_bit_cnt == `ACR_FRAME_BITS);
    wire [23:0] write_word = {in_shift[22:0], sdio_sync[1]};

    always @(posedge clock_i) begin
        if (rst_i) begin
            bit_cnt           <= 6'h00;
            cmd               <= 8'h00;
            in_shift          <= 24'h000000;
            out_shift         <= 24'h000000;
            serial_data_out_o <= 1'b0;
        end else if (!cs_active) begin
            // a frame cut short by cs high is dropped and leaves both words untouched
            bit_cnt           <= 6'h00;
            serial_data_out_o <= 1'b0;
        end else begin
            // edges past the thirty-second are ignored until cs rises again
            if (fall_ev && bit_cnt != `ACR_FRAME_BITS) begin
                bit_cnt <= next_bit_cnt;
                if (!in_data) begin
                    cmd <= {cmd[6:0], sdio_sync[1]};
                end else begin
                    in_shift <= write_word;
                end
                // load the read word as the command byte completes; the select bit
                // is the last command bit and is still on the data line, not yet in cmd
                if (next_bit_cnt == `ACR_CMD_BITS) begin
                    if (sdio_sync[1] == `ACR_SEL_FULLSCALE) begin
                        out_shift <= fullscale_correction_o;
                    end else begin
                        out_shift <= offset_correction_o;
                    end
                end
            end
            if (rise_ev && in_data && cmd_read && bit_cnt != `ACR_FRAME_BITS) begin
                serial_data_out_o <= out_shift[23];
                out_shift         <= {out_shift[22:0], 1'b0};
            end
        end
    end

// ---------------------------------------------------------------
// correction words
// ---------------------------------------------------------------
    always @(posedge clock_i) begin
        if (rst_i) begin
            offset_correction_o    <= `ACR_OFFSET_RST;
            fullscale_correction_o <= `ACR_FULLSCALE_RST;
        end else begin
            // a finished calibration takes priority over a host write in the same cycle
            if (cal_offset_load_i) begin
                offset_correction_o <= cal_word_i;
            end else if (write_done && cmd_sel == `ACR_SEL_OFFSET) begin
                offset_correction_o <= write_word;
            end
            if (cal_fullscale_load_i) begin
                fullscale_correction_o <= cal_word_i;
            end else if (write_done && cmd_sel == `ACR_SEL_FULLSCALE) begin
                fullscale_correction_o <= write_word;
            end
        end
    end

// ---------------------------------------------------------------
// result correction and output register
// ---------------------------------------------------------------
    // offset word is signed, full-scale word unsigned with unity at 2^22
    // both words are zero after reset, so results read the zero code until the full-scale word is loaded
    // clipping trades a silent wrap-around for a pinned full-scale code
    wire signed [24:0] diff    = $signed({raw_result_i[23], raw_result_i})
                               - $signed({offset_correction_o[23], offset_correction_o});
    wire signed [48:0] product = diff * $signed({1'b0, fullscale_correction_o});
    wire signed [48:0] scaled  = product >>> `ACR_GAIN_SHIFT;
    wire        [23:0] corrected = saturate(scaled);
    wire        [23:0] coded = output_format_select_i ?
                               {~corrected[23], corrected[22:0]} : corrected;

    always @(posedge clock_i) begin
        if (rst_i) begin
            output_result_register_o <= 24'h000000;
            result_ready_n_o         <= 1'b1;
        end else if (raw_valid_i) begin
            // a new result wins over an acknowledge in the same cycle
            output_result_register_o <= coded;
            result_ready_n_o         <= 1'b0;
        end else if (result_ack_i) begin
            result_ready_n_o         <= 1'b1;
        end
    end

endmodule

/* hdl/acr_defs.vh */
// constants for the converter calibration register block
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
// ---------------------------------------------------------------
// register selects carried in the command byte
// ---------------------------------------------------------------
`define ACR_SEL_OFFSET      1'h0
`define ACR_SEL_FULLSCALE   1'h1
// ---------------------------------------------------------------
// command byte fields
// ---------------------------------------------------------------
`define ACR_CMD_READ_BIT    7
`define ACR_CMD_SEL_BIT     0
`define ACR_CMD_BITS        6'h08
`define ACR_FRAME_BITS      6'h20
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ACR_OFFSET_RST      24'h000000
`define ACR_FULLSCALE_RST   24'h000000
// ---------------------------------------------------------------
// correction arithmetic
// ---------------------------------------------------------------
`define ACR_GAIN_SHIFT      22
`define ACR_RESULT_MAX      24'h7FFFFF
`define ACR_RESULT_MIN      24'h800000
// ---------------------------------------------------------------
// serial clock timing in master clock periods
// ---------------------------------------------------------------
`define ACR_SCLK_HIGH_PERIODS  2
`define ACR_SCLK_LOW_PERIODS   2
`define ACR_SCLK_HIGH_CYCLES   2'h1
`define ACR_SCLK_LOW_CYCLES    2'h1
`endif

/* tb/acr_cal_regs_assertions.sv */
// port assertions for the calibration register block
`timescale 1ns/1ps
module acr_cal_regs_assertions (
    input wire        clock_i,
    input wire        rst_i,
    input wire        output_format_select_i,
    input wire [23:0] raw_result_i,
    input wire        raw_valid_i,
    input wire        result_ack_i,
    input wire        cal_offset_load_i,
    input wire        cal_fullscale_load_i,
    input wire [23:0] cal_word_i,
    input wire        sclk_o,
    input wire        sclk_oe_n_o,
    input wire [23:0] output_result_register_o,
    input wire        result_ready_n_o,
    input wire [23:0] offset_correction_o,
    input wire [23:0] fullscale_correction_o
);
// ---------------------------------------------------------------
// port rules
// ---------------------------------------------------------------
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
sequence high_two_s;
    sclk_o ##1 !sclk_o;
endsequence
ready_set_a: assert property (raw_valid_i |=> !result_ready_n_o)
    else $error("ready not low after result");
ready_clr_a: assert property (result_ack_i && !raw_valid_i |=> result_ready_n_o)
    else $error("ready not released by ack");
result_hold_a: assert property (!raw_valid_i |=> $stable(output_result_register_o))
    else $error("result moved without new sample");
offs_load_a: assert property (cal_offset_load_i |=> offset_correction_o == $past(cal_word_i))
    else $error("offset word not loaded");
fs_load_a: assert property (cal_fullscale_load_i |=> fullscale_correction_o == $past(cal_word_i))
    else $error("full-scale word not loaded");
unity_gain_a: assert property (raw_valid_i && offset_correction_o == 24'h000000
    && fullscale_correction_o == 24'h400000 |=> output_result_register_o ==
    ($past(raw_result_i) ^ {$past(output_format_select_i), 23'h000000}))
    else $error("unity correction wrong");
sclk_high_a: assert property ($rose(sclk_o) |=> high_two_s)
    else $error("serial clock high phase not two");
sclk_low_a: assert property ($fell(sclk_o) |=> !sclk_o)
    else $error("serial clock low phase too short");
sclk_drive_a: assert property (sclk_o |-> !sclk_oe_n_o)
    else $error("serial clock toggles undriven");
endmodule
bind acr_cal_regs acr_cal_regs_assertions chk (.clock_i(clock_i), .rst_i(rst_i),
    .output_format_select_i(output_format_select_i), .raw_result_i(raw_result_i),
    .raw_valid_i(raw_valid_i), .result_ack_i(result_ack_i), .cal_word_i(cal_word_i),
    .cal_offset_load_i(cal_offset_load_i), .cal_fullscale_load_i(cal_fullscale_load_i),
    .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o), .result_ready_n_o(result_ready_n_o),
    .output_result_register_o(output_result_register_o),
    .offset_correction_o(offset_correction_o), .fullscale_correction_o(fullscale_correction_o));

/* tb/acr_host_model.sv */
// serial host model: frames in slave or master clocking
`timescale 1ns/1ps
module acr_host_model (
    input  wire clock_i,
    input  wire master_mode_i,
    input  wire dev_sclk_i,
    input  wire dev_data_i,
    output reg  cs_n_o   = 1'h1,
    output reg  sclk_h_o = 1'h0,
    output reg  sdio_o   = 1'h1
);
// ---------------------------------------------------------------
// one 32-bit frame, command then word, msb first
// ---------------------------------------------------------------
task xfer(input [7:0] c, input [23:0] w, output [23:0] r);
    reg [31:0] sh;
    integer    i;
    begin
        sh = {c, w};
        r = 24'h000000;
        // first bit is set up with the select, before the device clock can start
        @(posedge clock_i);
        cs_n_o <= 1'h0;
        sdio_o <= sh[31];
        repeat (4) @(posedge clock_i);
        for (i = 31; i >= 0; i = i - 1) begin
            if (master_mode_i) begin
                @(negedge dev_sclk_i) r = {r[22:0], dev_data_i};
                if (i > 0) begin
                    @(posedge clock_i);
                    sdio_o <= sh[i - 1];
                end
            end else begin
                repeat (4) @(posedge clock_i);
                sdio_o <= sh[i];
                repeat (4) @(posedge clock_i);
                sclk_h_o <= 1'h1;
                repeat (8) @(posedge clock_i);
                r = {r[22:0], dev_data_i};
                sclk_h_o <= 1'h0;
            end
        end
        // hold the select past the synchronised last edge, then release
        repeat (4) @(posedge clock_i);
        cs_n_o <= 1'h1;
        // released line shows the inverse, not a stale bit
        sdio_o <= ~sdio_o;
        repeat (6) @(posedge clock_i);
    end
endtask
endmodule

/* tb/acr_cal_regs_test.sv */
// self-checking bench for the calibration register block
`timescale 1ns/1ps
module acr_cal_regs_test;
reg         clock_i = 0, rst_i = 1, mm = 0, fmt = 0, rv = 0, ack = 0, lo = 0, lf = 0;
reg  [23:0] raw = 0, cw = 0, rd;
wire        sclk_o, oe_n, sdo, rdy_n, cs_n, hsclk, sdio;
wire [23:0] res, offs_w, fs_w;
integer     err_count = 0, total_checks = 0, cyc = 0;
always #5 clock_i = ~clock_i;
acr_cal_regs uut (.clock_i(clock_i), .rst_i(rst_i), .master_mode_i(mm),
    .output_format_select_i(fmt), .raw_result_i(raw), .raw_valid_i(rv), .result_ack_i(ack),
    .cal_offset_load_i(lo), .cal_fullscale_load_i(lf), .cal_word_i(cw), .cs_n_i(cs_n),
    .sclk_i(oe_n ? hsclk : sclk_o), .sdio_i(sdio), .sclk_o(sclk_o), .sclk_oe_n_o(oe_n),
    .serial_data_out_o(sdo), .output_result_register_o(res), .result_ready_n_o(rdy_n),
    .offset_correction_o(offs_w), .fullscale_correction_o(fs_w));
acr_host_model host (.clock_i(clock_i), .master_mode_i(mm), .dev_sclk_i(sclk_o),
    .dev_data_i(sdo), .cs_n_o(cs_n), .sclk_h_o(hsclk), .sdio_o(sdio));
// ---------------------------------------------------------------
// shared tasks
// ---------------------------------------------------------------
task chk(input [23:0] got, input [23:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
// hang guard: full run needs about 2400 cycles
always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
        err_count = err_count + 1;
        report_and_stop;
    end
end
task load(input f, input [23:0] w);
    @(posedge clock_i) {lo, lf, cw} <= {!f, f, w};
    @(posedge clock_i) {lo, lf} <= 2'h0;
    @(posedge clock_i) #1;
    chk(f ? fs_w : offs_w, w);
endtask
task conv(input [23:0] r, input f, input [23:0] e);
    @(posedge clock_i) {raw, rv, fmt} <= {r, 1'h1, f};
    @(posedge clock_i) rv <= 1'h0;
    @(posedge clock_i) #1;
    chk(res, e);
    chk({23'h0, rdy_n}, 24'h0);
    @(posedge clock_i) ack <= 1'h1;
    @(posedge clock_i) ack <= 1'h0;
    @(posedge clock_i) #1;
    chk({23'h0, rdy_n}, 24'h1);
endtask
// ---------------------------------------------------------------
// scenarios
// ---------------------------------------------------------------
task t_cal;
    load(0, 24'hFFFFF0);
    load(1, 24'h400000);
    conv(24'h000100, 0, 24'h000110);
    conv(24'h000100, 1, 24'h800110);
    load(1, 24'h800000);
    conv(24'h000100, 0, 24'h000220);
    conv(24'h7FFFFF, 0, 24'h7FFFFF);
    conv(24'h800000, 0, 24'h800000);
    $display("test cal done");
endtask
task t_serial;
    host.xfer(8'h01, 24'h400000, rd);
    chk(fs_w, 24'h400000);
    host.xfer(8'h80, 24'h000000, rd);
    chk(rd, 24'hFFFFF0);
    host.xfer(8'h00, 24'h000020, rd);
    chk(offs_w, 24'h000020);
    conv(24'h000100, 0, 24'h0000E0);
    @(posedge clock_i) mm <= 1'h1;
    repeat (4) @(posedge clock_i);
    host.xfer(8'h81, 24'h000000, rd);
    chk(rd, 24'h400000);
    host.xfer(8'h01, 24'h3FFFFF, rd);
    chk(fs_w, 24'h3FFFFF);
    $display("test serial done");
endtask
task t_average;
    reg [25:0] sum;
    sum = 26'h0;
    load(0, 24'h000010);
    host.xfer(8'h80, 24'h000000, rd);
    chk(rd, 24'h000010);
    sum = sum + {{2{rd[23]}}, rd};
    load(0, 24'h000030);
    host.xfer(8'h80, 24'h000000, rd);
    chk(rd, 24'h000030);
    sum = sum + {{2{rd[23]}}, rd};
    host.xfer(8'h00, sum[24:1], rd);
    chk(offs_w, 24'h000020);
    load(0, 24'h000000);
    load(1, 24'h400000);
    conv(24'h123456, 1, 24'h923456);
    $display("test average done");
endtask
initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'h0;
    @(posedge clock_i) #1;
    chk(offs_w, 24'h0);
    chk(fs_w, 24'h0);
    conv(24'h000100, 0, 24'h000000);
    $display("test reset done");
    t_cal;
    t_serial;
    t_average;
    report_and_stop;
end
endmodule
